// ---- common/hss_pkg.sv ----
package hss_pkg;

  // Internal conversion clock, in ns
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned TICK_PERIOD_NS   = 10000;
  localparam int unsigned TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST        = 12'(TICK_CYCLES - 1);

  // Conversion sequence lengths, in internal ticks
  localparam logic [4:0]  TRIG_TICKS       = 5'h01;
  localparam logic [4:0]  AWAKE_TICKS      = 5'h0c;
  localparam logic [4:0]  UPDATE_TICKS     = 5'h01;
  localparam logic [4:0]  FREE_GAP_TICKS   = 5'h02;
  localparam logic [4:0]  PULSE_CONV_TICKS = 5'h0e;
  localparam logic [4:0]  FREE_CONV_TICKS  = 5'h10;

  // Code layout
  localparam int unsigned CODE_W           = 8;
  localparam logic [7:0]  CODE_MID         = 8'h80;
  localparam logic [7:0]  CODE_RESET       = 8'h80;

  typedef enum logic [2:0] {
    HSS_SLEEP,
    HSS_TRIG,
    HSS_AWAKE,
    HSS_UPDATE,
    HSS_GAP
  } hss_phase_t;

  // Signed field sample split into sign and magnitude
  typedef struct packed {
    logic       neg;
    logic [6:0] mag;
  } hss_field_t;

endpackage

// ---- rtl/hss_quantizer.sv ----
`timescale 1ns/10ps
`default_nettype none
module hss_quantizer
  import hss_pkg::*;
(
  // Field sample in
  input  wire hss_field_t      field,
  // Offset-binary code out
  output logic [CODE_W-1:0]   code
);

  // Zero field lands on midscale, just below goes one lower
  always_comb begin
    if (field.neg) begin
      code = CODE_MID - 8'h01 - {1'b0, field.mag};
    end else begin
      code = CODE_MID + {1'b0, field.mag};
    end
  end

endmodule // hss_quantizer
`default_nettype wire

// ---- rtl/hss_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module hss_sequencer
  import hss_pkg::*;
(
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // Enable pin, asynchronous to clock
  input  wire logic            enable_pin,
  input  wire logic            enable_pin_oe,
  // Field sample from the sensing front end
  input  wire hss_field_t      field,
  // Outputs
  output logic [CODE_W-1:0]    out_code,
  output logic                 front_end_awake,
  output logic                 update_strobe,
  output logic                 busy
);

  typedef struct packed {
    logic [1:0]        sync1;     // {pin level, pin driven}
    logic [1:0]        sync2;
    logic              en_prev;
    logic              free_run;
    hss_phase_t        phase;
    logic [11:0]       tick_cnt;
    logic [4:0]        step;
    logic [CODE_W-1:0] sample;
    logic [CODE_W-1:0] code;
    logic              strobe;
    logic [4:0]        conv_cnt;  // Ticks since the conversion began
  } hss_state_t;

  hss_state_t        st_reg;
  hss_state_t        st_next;
  logic              en_sync;
  logic              tick;
  logic [CODE_W-1:0] q_code;
  logic [4:0]        conv_ticks;

  hss_quantizer hss_quantizer_inst (
    .field (field),
    .code  (q_code)
  );

  // Pin level and drive flag pass two flops each before the gate, so no
  // logic sits ahead of the first flop. If both bits move in one cycle the
  // two synchronisers may resolve a cycle apart and show a one-cycle blip.
  // A pin nobody drives reads low, standing in for the internal pull-down.
  assign en_sync    = st_reg.sync2[1] & st_reg.sync2[0];
  assign tick       = (st_reg.tick_cnt == TICK_LAST);
  assign conv_ticks = st_reg.conv_cnt;

  // Next-state logic for the whole sequencer
  always_comb begin
    st_next          = st_reg;
    st_next.sync1    = {enable_pin, enable_pin_oe};
    st_next.sync2    = st_reg.sync1;
    st_next.en_prev  = en_sync;
    st_next.strobe   = 1'b0;
    st_next.tick_cnt = tick ? 12'h000 : st_reg.tick_cnt + 12'h001;
    // Length counter restarts in sleep and after each update strobe
    if (st_reg.phase == HSS_SLEEP || st_reg.strobe) begin
      st_next.conv_cnt = 5'h00;
    end else if (tick) begin
      st_next.conv_cnt = st_reg.conv_cnt + 5'h01;
    end
    unique case (st_reg.phase)
      HSS_SLEEP: begin
        // Rising edge starts one conversion; low keeps sleeping.
        // Edge detector resets low, matching the idle pin, so no false start
        st_next.tick_cnt = 12'h000;
        if (en_sync && !st_reg.en_prev) begin
          st_next.phase = HSS_TRIG;
          st_next.step  = 5'h00;
        end
      end
      HSS_TRIG: begin
        // Front end stays low power during trigger delay
        if (tick) begin
          st_next.step  = st_reg.step + 5'h01;
          if (st_reg.step + 5'h01 == TRIG_TICKS) begin
            st_next.phase = HSS_AWAKE;
            st_next.step  = 5'h00;
          end
        end
      end
      HSS_AWAKE: begin
        // Sample captured on the last awake tick
        if (tick) begin
          st_next.step = st_reg.step + 5'h01;
          if (st_reg.step + 5'h01 == AWAKE_TICKS) begin
            st_next.sample = q_code;
            st_next.phase  = HSS_UPDATE;
            st_next.step   = 5'h00;
          end
        end
      end
      HSS_UPDATE: begin
        // Output changes only here, so it holds otherwise
        if (tick) begin
          st_next.code   = st_reg.sample;
          st_next.strobe = 1'b1;
          // Pin still high at update time means free running continues
          if (en_sync) begin
            st_next.free_run = 1'b1;
            st_next.phase    = HSS_GAP;
            st_next.step     = 5'h00;
          end else begin
            st_next.free_run = 1'b0;
            st_next.phase    = HSS_SLEEP;
          end
        end
      end
      HSS_GAP: begin
        // Pads free-run conversions to sixteen ticks; a low pin here
        // drops straight back to sleep without waiting for a tick
        if (!en_sync) begin
          st_next.phase    = HSS_SLEEP;
          st_next.free_run = 1'b0;
        end else if (tick) begin
          st_next.step = st_reg.step + 5'h01;
          if (st_reg.step + 5'h01 == FREE_GAP_TICKS) begin
            st_next.phase = HSS_TRIG;
            st_next.step  = 5'h00;
          end
        end
      end
      default: begin
        st_next.phase = HSS_SLEEP;
      end
    endcase
    // Edges during TRIG/AWAKE/UPDATE are ignored by the case above
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{sync1: 2'h0, sync2: 2'h0, en_prev: 1'b0, free_run: 1'b0,
                 phase: HSS_SLEEP, tick_cnt: 12'h000, step: 5'h00,
                 sample: CODE_RESET, code: CODE_RESET, strobe: 1'b0,
                 conv_cnt: 5'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_code        = st_reg.code;
  assign update_strobe   = st_reg.strobe;
  assign front_end_awake = (st_reg.phase == HSS_AWAKE);
  assign busy            = (st_reg.phase == HSS_TRIG) || (st_reg.phase == HSS_AWAKE)
                           || (st_reg.phase == HSS_UPDATE);

  // Synchronised rising edge seen while asleep
  sequence start_s;
    st_reg.phase == HSS_SLEEP && en_sync && !st_reg.en_prev;
  endsequence

  // Awake phase has just ended
  sequence awake_end_s;
    $fell(front_end_awake);
  endsequence

  // Low enable never wakes the sequencer
  sleep_holds_a: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.phase == HSS_SLEEP && !en_sync) |=> st_reg.phase == HSS_SLEEP)
    else $error("left sleep without enable");

  // Floating pin settles to a low synchronised level
  pulldown_sleep_a: assert property (@(posedge clock) disable iff (sys_rst)
    !enable_pin_oe [*3] |=> !en_sync)
    else $error("floating enable not read low");

  // Each synchronised edge in sleep opens a conversion
  start_trig_a: assert property (@(posedge clock) disable iff (sys_rst)
    start_s |=> st_reg.phase == HSS_TRIG)
    else $error("edge did not start conversion");

  // Trigger delay hands over to the awake phase after one tick
  trig_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.phase == HSS_TRIG && tick) |=> st_reg.phase == HSS_AWAKE && front_end_awake)
    else $error("trigger delay wrong");

  // Awake phase is not cut short right after it opens
  awake_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(front_end_awake) |-> front_end_awake [*8])
    else $error("awake period cut short");

  // Awake phase closes after the trigger delay plus twelve ticks
  awake_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    awake_end_s |-> conv_ticks == (st_reg.free_run ? FREE_GAP_TICKS : 5'h00)
      + TRIG_TICKS + AWAKE_TICKS)
    else $error("awake period length wrong");

  // Fourteen ticks from an edge, sixteen between free-run updates
  pulse_conv_a: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.phase == HSS_UPDATE && tick) |->
      conv_ticks == (st_reg.free_run ? FREE_CONV_TICKS : PULSE_CONV_TICKS) - 5'h01)
    else $error("conversion length wrong");

  // Dropping enable during the gap ends free running
  gap_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (st_reg.phase == HSS_GAP && !en_sync) |=> st_reg.phase == HSS_SLEEP)
    else $error("free run kept going without enable");

  // Output moves only together with the update strobe
  update_only_a: assert property (@(posedge clock) disable iff (sys_rst)
    !st_reg.strobe |-> $stable(out_code))
    else $error("output changed outside update");

  // Strobe carries the sample taken at the end of the awake phase
  strobe_code_a: assert property (@(posedge clock) disable iff (sys_rst)
    st_reg.strobe |-> out_code == $past(st_reg.sample))
    else $error("update did not load sample");

  // Edge inside a conversion leaves phase and step alone
  no_restart_a: assert property (@(posedge clock) disable iff (sys_rst)
    (busy && !tick && en_sync && !st_reg.en_prev) |=>
      $stable(st_reg.phase) && $stable(st_reg.step))
    else $error("conversion disturbed");

endmodule // hss_sequencer
`default_nettype wire

// ---- tb/hss_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module hss_host_model (
  // Enable pin as the sensor sees it
  output var logic enable_pin,
  output var logic enable_pin_oe
);
  // Driven low at start; a released pin may still carry noise
  initial begin
    enable_pin    = 1'b0;
    enable_pin_oe = 1'b1;
  end
  // Pulse rate and width are left to the caller
  task automatic set_pin(input logic lvl, input logic drv);
    enable_pin    = lvl;
    enable_pin_oe = drv;
  endtask
endmodule // hss_host_model
`default_nettype wire

// ---- tb/test_hss_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_hss_sequencer
  import hss_pkg::*;
;
  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              enable_pin;
  logic              enable_pin_oe;
  hss_field_t        field = '0;
  logic [CODE_W-1:0] out_code;
  logic              front_end_awake;
  logic              update_strobe;
  logic              busy;
  int                fails = 0;
  int                cmp_count = 0;
  int                st;
  int                aw0;
  int                awn;
  int                bsy;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  hss_host_model hss_host_model_inst (
    .enable_pin    (enable_pin),
    .enable_pin_oe (enable_pin_oe)
  );
  hss_sequencer hss_sequencer_inst (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .enable_pin      (enable_pin),
    .enable_pin_oe   (enable_pin_oe),
    .field           (field),
    .out_code        (out_code),
    .front_end_awake (front_end_awake),
    .update_strobe   (update_strobe),
    .busy            (busy)
  );

  // Shared compare
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Next edge plus the fixed drive delay, so outputs have settled
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Idle span: no strobe, no busy, code held
  task automatic quiet(input int n, input logic [7:0] code);
    logic act;
    act = 1'b0;
    repeat (n) begin
      step();
      act = act | busy | update_strobe;
    end
    check(act, 1'b0);
    check(out_code, code);
  endtask

  // Follow one conversion; mid adds a second rising edge inside it
  task automatic conv(input bit mid);
    st = 0;
    aw0 = 0;
    awn = 0;
    bsy = 0;
    for (int n = 1; n <= 33000 && st == 0; n++) begin
      step();
      if (mid && n == 8000) hss_host_model_inst.set_pin(1'b0, 1'b1);
      if (mid && n == 12000) hss_host_model_inst.set_pin(1'b1, 1'b1);
      if (mid && n == 20000) hss_host_model_inst.set_pin(1'b0, 1'b1);
      if (front_end_awake === 1'b1) begin
        if (awn == 0) aw0 = n;
        awn++;
      end
      if (busy === 1'b1) bsy++;
      if (update_strobe === 1'b1) st = n;
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Scenario: held low, then floating pin, both stay asleep
  task automatic sleep_scenario();
    quiet(1000, CODE_RESET);
    hss_host_model_inst.set_pin(1'b1, 1'b0);
    quiet(1000, CODE_RESET);
  endtask

  // Scenario: one 40 us pulse plus a second edge mid-conversion
  task automatic pulse_scenario();
    field = '{neg: 1'b0, mag: 7'h05};
    hss_host_model_inst.set_pin(1'b1, 1'b1);
    conv(1'b1);
    check(st >= 27995 && st <= 28010, 1'b1);
    check(aw0 >= 1998 && aw0 <= 2010, 1'b1);
    check(awn, 24000);
    check(bsy, 28000);
    check(out_code, 8'h85);
    step();
    check(update_strobe, 1'b0);
    quiet(2000, 8'h85);
  endtask

  // Scenario: enable held high, then dropped during the gap
  task automatic free_run_scenario();
    field = '{neg: 1'b1, mag: 7'h03};
    hss_host_model_inst.set_pin(1'b1, 1'b1);
    conv(1'b0);
    check(out_code, 8'h7c);
    field = '{neg: 1'b1, mag: 7'h00};
    conv(1'b0);
    check(st, 32000);
    check(awn, 24000);
    check(bsy, 28000);
    check(out_code, 8'h7f);
    hss_host_model_inst.set_pin(1'b0, 1'b1);
    quiet(3000, 8'h7f);
  endtask

  // Main sequence: sleep, pulse mode, free-run
  initial begin
    repeat (5) @(posedge clock);
    #1 sys_rst = 1'b0;
    sleep_scenario();
    pulse_scenario();
    free_run_scenario();
    final_report();
  end

  // Whole run needs about 475 us; cut a hang shortly after
  initial begin
    #490000;
    fails++;
    final_report();
  end
endmodule // test_hss_sequencer
`default_nettype wire
